// >>> rtl/fds_core.sv
`timescale 1ns/1ps
module fds_core
  import fds_pkg::*;
#(
  parameter int ADDR_W = FDS_ADDR_W,
  parameter int DEPTH  = FDS_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_nrst,
  // Byte stream from serial port or master socket
  input  wire logic              i_load_start,
  input  wire fds_src_t          i_load_src,
  input  wire logic              i_byte_valid,
  output logic                   o_byte_ready,
  input  wire fds_byte_t         i_byte,
  // Sumcheck sent by host with the transfer
  input  wire logic              i_host_sum_valid,
  input  wire logic [15:0]       i_host_sum,
  // Settings
  input  wire logic              i_parity_en,
  input  wire logic              i_term_mode,
  input  wire logic              i_sig_en,
  input  wire logic              i_vectors_present,
  // Fuse data RAM write port
  output logic                   o_fuse_we,
  output logic [ADDR_W-1:0]      o_fuse_addr,
  output logic [7:0]             o_fuse_wdata,
  // Source holding buffer write port
  output logic                   o_src_we,
  // Test engine handshake
  input  wire logic              i_prog_cycle,
  output fds_test_t              o_test,
  output logic                   o_test_go,
  input  wire logic              i_test_done,
  input  wire logic              i_test_pass,
  // Display
  output fds_disp_t              o_disp,
  output logic [FDS_HEX_DIGITS*8-1:0] o_hex_ascii,
  output logic                   o_busy
);

  initial begin
    if (ADDR_W < 1 || ADDR_W > 24) $error("ADDR_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input buffering; back-pressure reaches the source
  fds_byte_t fifo_out;
  logic      fifo_valid;
  logic      fifo_ready;

  fds_fifo #(.WIDTH($bits(fds_byte_t)), .DEPTH(DEPTH)) u_fifo (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_valid    (i_byte_valid),
    .o_ready    (o_byte_ready),
    .i_data     (i_byte),
    .o_valid    (fifo_valid),
    .i_ready    (fifo_ready),
    .o_data     (fifo_out)
  );

  function automatic logic [7:0] hex_char(input logic [3:0] nib);
    hex_char = (nib < 4'ha) ? (8'h30 + {4'h0, nib}) : (8'h37 + {4'h0, nib});
  endfunction : hex_char

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  typedef enum logic [3:0] {
    ST_SELF, ST_SELF_W, ST_IDLE, ST_LOAD, ST_CMP, ST_VERIFY, ST_VERIFY_W,
    ST_VEC, ST_VEC_W, ST_SIG, ST_SIG_W
  } fds_state_t;

  fds_state_t  state;
  fds_src_t    src;
  logic [15:0] sum;
  logic [15:0] host_sum;
  logic        host_sum_seen;
  logic        par_ok;
  logic [ADDR_W-1:0] addr;
  fds_src_t    next_src;

  logic take;
  assign fifo_ready = (state == ST_LOAD);
  assign take       = fifo_valid && fifo_ready;
  assign par_ok     = ^{fifo_out.data, fifo_out.par};   // Odd parity
  // Source as it stands after this edge, so a sum sent with the start pulse counts
  assign next_src   = (state == ST_IDLE && i_load_start) ? i_load_src : src;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= ST_SELF;
    end else begin
      unique case (state)
        ST_SELF:     state <= ST_SELF_W;
        ST_SELF_W:   if (i_test_done) state <= ST_IDLE;
        ST_IDLE: begin
          if (i_load_start) state <= ST_LOAD;
          else if (i_prog_cycle) state <= ST_VERIFY;
        end
        ST_LOAD: begin
          // Abort leaves unread bytes in the FIFO; a later load takes them in
          if (take && src == FDS_SRC_SERIAL && i_parity_en && !par_ok)
            state <= ST_IDLE;
          else if (take && fifo_out.last) state <= ST_CMP;
        end
        ST_CMP:      state <= ST_IDLE;
        ST_VERIFY:   state <= ST_VERIFY_W;
        ST_VERIFY_W: begin
          if (i_test_done) begin
            if (!i_test_pass) state <= ST_IDLE;
            else if (i_vectors_present) state <= ST_VEC;
            else if (i_sig_en) state <= ST_SIG;
            else state <= ST_IDLE;
          end
        end
        ST_VEC:      state <= ST_VEC_W;
        ST_VEC_W: begin
          if (i_test_done) begin
            if (i_test_pass && i_sig_en) state <= ST_SIG;
            else state <= ST_IDLE;
          end
        end
        ST_SIG:      state <= ST_SIG_W;
        ST_SIG_W:    if (i_test_done) state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sumcheck accumulation and RAM writes
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sum  <= FDS_SUM_RST;
      addr <= '0;
      src  <= FDS_SRC_SERIAL;
    end else if (state == ST_IDLE && i_load_start) begin
      sum  <= FDS_SUM_RST;
      addr <= '0;
      src  <= i_load_src;
    end else if (take) begin
      sum  <= sum + {8'h00, fifo_out.data};
      addr <= addr + 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_fuse_we    <= 1'b0;
      o_fuse_addr  <= '0;
      o_fuse_wdata <= 8'h00;
    end else begin
      o_fuse_we    <= take;
      o_fuse_addr  <= addr;
      o_fuse_wdata <= fifo_out.data;
    end
  end

  // Fuse loads never touch the holding buffer
  assign o_src_we = 1'b0;

  // Host sumcheck capture; a later sample in the same load replaces it
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      host_sum      <= FDS_SUM_RST;
      host_sum_seen <= 1'b0;
    end else if (i_host_sum_valid && next_src == FDS_SRC_SERIAL) begin
      host_sum      <= i_host_sum;
      host_sum_seen <= 1'b1;
    end else if (state == ST_IDLE && i_load_start) begin
      host_sum_seen <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test launch
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_test    <= FDS_T_NONE;
      o_test_go <= 1'b0;
    end else begin
      o_test_go <= 1'b0;
      unique case (state)
        ST_SELF:   begin o_test <= FDS_T_SELF;   o_test_go <= 1'b1; end
        ST_VERIFY: begin o_test <= FDS_T_VERIFY; o_test_go <= 1'b1; end
        ST_VEC:    begin o_test <= FDS_T_VECTOR; o_test_go <= 1'b1; end
        ST_SIG:    begin o_test <= FDS_T_SIG;    o_test_go <= 1'b1; end
        default:   ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Display; error holds until the next load or test
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_disp <= '{sum: FDS_SUM_RST, err: FDS_ERR_NONE, term: 1'b0};
    end else begin
      o_disp.term <= i_term_mode;
      if (state == ST_IDLE && (i_load_start || i_prog_cycle))
        o_disp.err <= FDS_ERR_NONE;
      if (state == ST_LOAD && take && src == FDS_SRC_SERIAL && i_parity_en && !par_ok)
        o_disp.err <= FDS_ERR_PARITY;
      if (state == ST_CMP) begin
        if (host_sum_seen && host_sum != sum)
          o_disp.err <= FDS_ERR_SUMCHECK;
        else
          o_disp.sum <= sum;
      end
      if (i_test_done && !i_test_pass) begin
        unique case (state)
          ST_SELF_W:   o_disp.err <= FDS_ERR_SELFTEST;
          ST_VERIFY_W: o_disp.err <= FDS_ERR_VERIFY;
          ST_VEC_W:    o_disp.err <= FDS_ERR_VECTOR;
          ST_SIG_W:    o_disp.err <= FDS_ERR_SIG;
          default:     ;
        endcase
      end
    end
  end

  always_comb begin
    for (int i = 0; i < FDS_HEX_DIGITS; i++) begin
      o_hex_ascii[i*8 +: 8] = hex_char(o_disp.sum[i*4 +: 4]);
    end
  end

  assign o_busy = (state != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_load_end;
    state == ST_CMP;
  endsequence

  sequence s_parity_bad;
    state == ST_LOAD && take && src == FDS_SRC_SERIAL && i_parity_en && !par_ok;
  endsequence

  sequence s_vec_pass_sig;
    state == ST_VEC_W && i_test_done && i_test_pass && i_sig_en;
  endsequence

  sum_shown_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    s_load_end and !(host_sum_seen && host_sum != sum) |=> o_disp.sum == $past(sum))
    else $error("sumcheck not shown");
  sum_mismatch_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    s_load_end and host_sum_seen && host_sum != sum |=> o_disp.err == FDS_ERR_SUMCHECK)
    else $error("mismatch not flagged");
  sum_accum_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    take && !(state == ST_IDLE) |=> sum == 16'($past(sum) + {8'h00, $past(fifo_out.data)}))
    else $error("bad accumulate");
  sum_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    state == ST_IDLE && i_load_start |=> sum == FDS_SUM_RST)
    else $error("sum not cleared");
  parity_gate_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    state == ST_LOAD && take && !i_parity_en && !fifo_out.last |=> state == ST_LOAD)
    else $error("parity checked while disabled");
  src_quiet_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    !o_src_we) else $error("holding buffer written");
  verify_go_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    state == ST_IDLE && !i_load_start && i_prog_cycle |=> ##1 o_test_go && o_test == FDS_T_VERIFY)
    else $error("verify not launched");
  vec_first_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    state == ST_VERIFY_W && i_test_done && i_test_pass && i_vectors_present
      |=> ##1 o_test == FDS_T_VECTOR) else $error("vectors not before signature");
  novec_sig_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    state == ST_VERIFY_W && i_test_done && i_test_pass && !i_vectors_present && !i_sig_en
      |=> state == ST_IDLE) else $error("extra test run");
  self_err_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    state == ST_SELF_W && i_test_done && !i_test_pass |=> o_disp.err == FDS_ERR_SELFTEST)
    else $error("self-test error not shown");
  self_go_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    state == ST_SELF |=> o_test_go && o_test == FDS_T_SELF)
    else $error("self-test not launched");
  parity_abort_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    s_parity_bad |=> state == ST_IDLE && o_disp.err == FDS_ERR_PARITY)
    else $error("parity error not flagged");
  fuse_write_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    take |=> o_fuse_we && o_fuse_wdata == $past(fifo_out.data) && o_fuse_addr == $past(addr))
    else $error("fuse byte not written");
  sig_after_vec_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    s_vec_pass_sig |=> ##1 o_test_go && o_test == FDS_T_SIG)
    else $error("signature test not launched after vectors");
  sig_no_vec_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    state == ST_VERIFY_W && i_test_done && i_test_pass && !i_vectors_present && i_sig_en
      |=> ##1 o_test_go && o_test == FDS_T_SIG) else $error("signature test skipped");
  master_nosum_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    state == ST_LOAD && src == FDS_SRC_MASTER |-> !host_sum_seen)
    else $error("host sum taken for master load");

endmodule : fds_core

// >>> rtl/fds_pkg.sv
package fds_pkg;

  // Sumcheck, data and address widths, display digit count and FIFO depth
  localparam int FDS_SUM_W      = 16;
  localparam int FDS_BYTE_W     = 8;
  localparam int FDS_ADDR_W     = 12;
  localparam int FDS_HEX_DIGITS = 4;
  localparam int FDS_FIFO_DEPTH = 4;

  // Reset values
  localparam logic [15:0] FDS_SUM_RST = 16'h0000;
  localparam logic [7:0]  FDS_ERR_NONE = 8'h00;

  // Error codes shown on the display
  localparam logic [7:0] FDS_ERR_SELFTEST = 8'h01;
  localparam logic [7:0] FDS_ERR_SUMCHECK = 8'h02;
  localparam logic [7:0] FDS_ERR_PARITY   = 8'h03;
  localparam logic [7:0] FDS_ERR_VERIFY   = 8'h04;
  localparam logic [7:0] FDS_ERR_VECTOR   = 8'h05;
  localparam logic [7:0] FDS_ERR_SIG      = 8'h06;

  // Load source
  typedef enum logic [0:0] {FDS_SRC_SERIAL, FDS_SRC_MASTER} fds_src_t;

  // Tests the sequencer can launch
  typedef enum logic [2:0] {
    FDS_T_NONE, FDS_T_SELF, FDS_T_VERIFY, FDS_T_VECTOR, FDS_T_SIG
  } fds_test_t;

  // One incoming fuse byte
  typedef struct packed {
    logic [7:0] data;
    logic       par;   // Odd parity bit from serial link
    logic       last;
  } fds_byte_t;

  // Display output
  typedef struct packed {
    logic [15:0] sum;
    logic [7:0]  err;
    logic        term;
  } fds_disp_t;

endpackage : fds_pkg

// >>> rtl/fds_fifo.sv
`timescale 1ns/1ps
module fds_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_nrst,
  // Fill side
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic [WIDTH-1:0]      o_data
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             wr_en;
  logic             rd_en;

  assign o_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign o_valid = wr_ptr != rd_ptr;
  assign wr_en   = i_valid && o_ready;
  assign rd_en   = o_valid && i_ready;
  assign o_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge i_core_clk) begin
    if (wr_en) begin
      mem[wr_ptr[AW-1:0]] <= i_data;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (wr_en) wr_ptr <= wr_ptr + 1'b1;
      if (rd_en) rd_ptr <= rd_ptr + 1'b1;
    end
  end

  full_no_write_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    !o_ready |=> wr_ptr == $past(wr_ptr)) else $error("write while full");
endmodule : fds_fifo

// >>> bench/fds_far_model.sv
`timescale 1ns/1ps
module fds_far_model
  import fds_pkg::*;
(
  // Clock and reset
  input  wire logic      i_core_clk,
  input  wire logic      i_nrst,
  // Byte stream
  output logic           o_valid,
  input  wire logic      i_ready,
  output fds_byte_t      o_byte,
  // Test engine
  input  wire logic      i_test_go,
  input  wire fds_test_t i_test,
  output logic           o_test_done,
  output logic           o_test_pass
);
  fds_test_t fail_at = FDS_T_NONE;
  fds_test_t seen[$];
  fds_test_t cur     = FDS_T_NONE;
  int        stall   = 0;
  int        cnt     = 0;
  logic      rdy_s   = 1'b0;

  initial begin
    o_valid     = 1'b0;
    o_byte      = '0;
    o_test_done = 1'b0;
    o_test_pass = 1'b0;
  end

  // Ready is combinational; read it once settled, well before the edge
  always @(negedge i_core_clk) rdy_s = i_ready;

  //////////////////////////////////////////////////////////////////////////
  // Source is never a secured part, so every byte is readable
  task automatic send(input logic [7:0] d, input logic last, input logic bad);
    if (stall > 0) begin
      o_valid <= 1'b0;
      o_byte  <= ~o_byte;
      repeat (stall) @(posedge i_core_clk);
    end
    o_byte  <= '{data: d, par: ~^d ^ bad, last: last};
    o_valid <= 1'b1;
    do @(posedge i_core_clk); while (rdy_s !== 1'b1);
  endtask : send

  // Released lines show garbage, not the last byte
  task automatic release_bus();
    o_valid <= 1'b0;
    o_byte  <= ~o_byte;
  endtask : release_bus

  //////////////////////////////////////////////////////////////////////////
  // Slow engine: done three cycles after each go
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt = 0;
      o_test_done <= 1'b0;
    end else if (i_test_go === 1'b1) begin
      seen.push_back(i_test);
      cur = i_test;
      cnt = 3;
      o_test_done <= 1'b0;
      o_test_pass <= ~o_test_pass;
    end else if (cnt == 1) begin
      cnt = 0;
      o_test_done <= 1'b1;
      o_test_pass <= (cur != fail_at);
    end else begin
      if (cnt > 1) cnt = cnt - 1;
      o_test_done <= 1'b0;
      o_test_pass <= ~o_test_pass;
    end
  end
endmodule : fds_far_model

// >>> bench/fds_core_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module fds_core_bench
  import fds_pkg::*;
;
  logic        core_clk = 1'b0, nrst = 1'b0, load_start = 1'b0, host_sum_valid = 1'b0;
  fds_src_t    load_src = FDS_SRC_SERIAL;
  logic [15:0] host_sum = 16'h0000;
  logic        parity_en = 1'b1, term_mode = 1'b1, sig_en = 1'b0, vectors_present = 1'b0;
  logic        prog_cycle = 1'b0, byte_valid, byte_ready, test_done, test_pass;
  logic        fuse_we, src_we, test_go, busy;
  fds_byte_t   byte_in;
  logic [11:0] fuse_addr;
  logic [7:0]  fuse_wdata;
  fds_test_t   test;
  fds_disp_t   disp;
  logic [31:0] hex_ascii;
  int          fail_count = 0, n_compared = 0, cycles = 0, src_hits = 0;
  logic [7:0]  wq[$];

  always #4 core_clk = ~core_clk;

  fds_core fds_core_inst (.i_core_clk(core_clk), .i_nrst(nrst), .i_load_start(load_start),
    .i_load_src(load_src), .i_byte_valid(byte_valid), .o_byte_ready(byte_ready),
    .i_byte(byte_in), .i_host_sum_valid(host_sum_valid), .i_host_sum(host_sum),
    .i_parity_en(parity_en), .i_term_mode(term_mode), .i_sig_en(sig_en),
    .i_vectors_present(vectors_present), .o_fuse_we(fuse_we), .o_fuse_addr(fuse_addr),
    .o_fuse_wdata(fuse_wdata), .o_src_we(src_we), .i_prog_cycle(prog_cycle), .o_test(test),
    .o_test_go(test_go), .i_test_done(test_done), .i_test_pass(test_pass), .o_disp(disp),
    .o_hex_ascii(hex_ascii), .o_busy(busy));
  fds_far_model far (.i_core_clk(core_clk), .i_nrst(nrst), .o_valid(byte_valid),
    .i_ready(byte_ready), .o_byte(byte_in), .i_test_go(test_go), .i_test(test),
    .o_test_done(test_done), .o_test_pass(test_pass));

  //////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    cycles++;
    if (fuse_we === 1'b1) begin
      wq.push_back(fuse_wdata);
      `CHK(fuse_addr, 12'(wq.size() - 1))
    end
    if (src_we !== 1'b0) src_hits++;
    if (cycles >= 20000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  task automatic wait_idle();
    for (int k = 0; k < 2000; k++) begin
      @(negedge core_clk);
      if (busy === 1'b0) break;
    end
    `CHK(busy, 1'b0)
    repeat (2) @(negedge core_clk);
  endtask : wait_idle

  task automatic load(input fds_src_t src, input logic [7:0] q[$], input int bad_at,
                      input logic hs_v, input logic [15:0] hs);
    wq.delete();
    @(posedge core_clk);
    load_start <= 1'b1;
    load_src   <= src;
    @(posedge core_clk);
    load_start     <= 1'b0;
    host_sum_valid <= hs_v;
    host_sum       <= hs;
    @(posedge core_clk);
    host_sum_valid <= 1'b0;
    foreach (q[i]) far.send(q[i], i == q.size() - 1, i == bad_at);
    far.release_bus();
    wait_idle();
  endtask : load

  //////////////////////////////////////////////////////////////////////////
  task automatic t_selftest(input logic bad);
    far.fail_at = bad ? FDS_T_SELF : FDS_T_NONE;
    far.seen.delete();
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    wait_idle();
    `CHK(far.seen.size(), 1)
    `CHK(far.seen[0], FDS_T_SELF)
    `CHK(disp.err, bad ? FDS_ERR_SELFTEST : FDS_ERR_NONE)
  endtask : t_selftest

  task automatic t_serial_sum();
    load(FDS_SRC_SERIAL, '{8'h84, 8'hc1, 8'h62, 8'h24}, -1, 1'b1, 16'h01cb);
    `CHK(disp.sum, 16'h01cb)
    `CHK(hex_ascii, 32'h30314342)
    `CHK(disp.err, FDS_ERR_NONE)
    `CHK(disp.term, 1'b1)
    `CHK(wq.size(), 4)
    `CHK(wq[3], 8'h24)
  endtask : t_serial_sum

  // Master data: parity and host sum must both be ignored
  task automatic t_master_wrap();
    logic [7:0] q[$];
    for (int i = 0; i < 257; i++) q.push_back(8'hff);
    q.push_back(8'h02);
    far.stall = 2;
    load(FDS_SRC_MASTER, q, 5, 1'b1, 16'h1234);
    far.stall = 0;
    `CHK(disp.sum, 16'h0001)
    `CHK(disp.err, FDS_ERR_NONE)
    `CHK(wq.size(), 258)
    `CHK(src_hits, 0)
  endtask : t_master_wrap

  task automatic t_sum_mismatch();
    @(posedge core_clk);
    term_mode <= 1'b0;
    load(FDS_SRC_SERIAL, '{8'h01, 8'h02}, -1, 1'b1, 16'h0004);
    `CHK(disp.err, FDS_ERR_SUMCHECK)
    `CHK(disp.sum, 16'h0001)
    `CHK(disp.term, 1'b0)
    @(posedge core_clk);
    term_mode <= 1'b1;
  endtask : t_sum_mismatch

  task automatic t_parity();
    @(posedge core_clk);
    parity_en <= 1'b0;
    load(FDS_SRC_SERIAL, '{8'h10, 8'h20}, 0, 1'b1, 16'h0030);
    `CHK(disp.sum, 16'h0030)
    `CHK(disp.err, FDS_ERR_NONE)
    @(posedge core_clk);
    parity_en <= 1'b1;
    load(FDS_SRC_SERIAL, '{8'h11, 8'h22}, 1, 1'b0, 16'h0000);
    `CHK(disp.err, FDS_ERR_PARITY)
    `CHK(disp.sum, 16'h0030)
  endtask : t_parity

  task automatic run_prog(input logic vec, input logic sig, input fds_test_t fail,
                          input fds_test_t e[$], input logic [7:0] err);
    far.fail_at = fail;
    far.seen.delete();
    @(posedge core_clk);
    vectors_present <= vec;
    sig_en          <= sig;
    prog_cycle      <= 1'b1;
    @(posedge core_clk);
    prog_cycle <= 1'b0;
    wait_idle();
    `CHK(far.seen.size(), e.size())
    foreach (e[i]) `CHK(far.seen[i], e[i])
    `CHK(disp.err, err)
  endtask : run_prog

  task automatic t_tests();
    run_prog(1, 1, FDS_T_NONE, '{FDS_T_VERIFY, FDS_T_VECTOR, FDS_T_SIG}, FDS_ERR_NONE);
    run_prog(0, 1, FDS_T_NONE, '{FDS_T_VERIFY, FDS_T_SIG}, FDS_ERR_NONE);
    run_prog(0, 0, FDS_T_NONE, '{FDS_T_VERIFY}, FDS_ERR_NONE);
    run_prog(1, 0, FDS_T_NONE, '{FDS_T_VERIFY, FDS_T_VECTOR}, FDS_ERR_NONE);
    run_prog(1, 1, FDS_T_VECTOR, '{FDS_T_VERIFY, FDS_T_VECTOR}, FDS_ERR_VECTOR);
    run_prog(0, 1, FDS_T_VERIFY, '{FDS_T_VERIFY}, FDS_ERR_VERIFY);
    run_prog(0, 1, FDS_T_SIG, '{FDS_T_VERIFY, FDS_T_SIG}, FDS_ERR_SIG);
  endtask : t_tests

  initial begin
    t_selftest(1'b0);
    t_serial_sum();
    t_master_wrap();
    t_sum_mismatch();
    t_parity();
    t_tests();
    t_selftest(1'b1);
    t_selftest(1'b0);
    summarize();
  end
endmodule : fds_core_bench
